// ===== verilog/lsd_pkg.sv
package lsd_pkg;
  // Serial word width and frame memory depth
  localparam int WORD_W = 16;
  localparam int NUM_WORDS = 16;
  // Strobe edge counter width, saturates at its top value
  localparam int CNT_W = 4;
  // Command codes: data clock edges seen while the strobe is high
  localparam logic [3:0] CMD_LATCH = 4'h1;
  localparam logic [3:0] CMD_VSYNC = 4'h2;
  localparam logic [3:0] CMD_WCFG1 = 4'h4;
  localparam logic [3:0] CMD_RCFG1 = 4'h5;
  localparam logic [3:0] CMD_DET_ON = 4'h7;
  localparam logic [3:0] CMD_WCFG2 = 4'h8;
  localparam logic [3:0] CMD_RCFG2 = 4'h9;
  localparam logic [3:0] CMD_SWRST = 4'hA;
  localparam logic [3:0] CMD_UNLOCK = 4'hE;
  // Configuration reset values
  localparam logic [15:0] CFG1_RST = 16'h032B;
  localparam logic [15:0] CFG2_RST = 16'h0000;
  // Latches needed after power-up before a frame update is honoured
  localparam logic [4:0] LATCH_MIN = 5'h10;
  // Open-LED detection time and its count at the reference clock
  localparam int REF_MHZ = 200;
  localparam int ERR_TIME_NS = 700;
  localparam int ERR_CYC = (ERR_TIME_NS * REF_MHZ + 999) / 1000;
  localparam int ERR_CNT_W = 8;
  // Crossing channel indices
  localparam int CDC_LATCH = 0;
  localparam int CDC_VSYNC = 1;
  localparam int CDC_SWRST = 2;
  localparam int CDC_DET = 3;
  localparam int CDC_CFG = 4;
  localparam int CDC_N = 5;
  // Display state and detection timer state
  typedef enum logic {DISP_OFF, DISP_ON} lsd_disp_t;
  typedef enum logic [1:0] {DET_IDLE, DET_RUN, DET_DONE} lsd_det_t;
endpackage

// ===== verilog/lsd_cdc_if.sv
`timescale 1ns/100ps
// One crossing channel: a toggle or level from the link side
interface lsd_cdc_if;
  logic src; // Driven on the link clock
  logic lvl; // Accepted level on the reference clock
  logic pulse; // One-cycle pulse per accepted change
  modport tx (output src, input lvl, input pulse);
  modport rx (input src, output lvl, output pulse);
endinterface // lsd_cdc_if

// ===== verilog/lsd_evt_sync.sv
`timescale 1ns/100ps
module lsd_evt_sync
  import lsd_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  lsd_cdc_if.rx port
);
  logic s1_reg; // First stage, read only by the second
  logic s2_reg;
  logic s3_reg;
  logic acc_reg; // Accepted level
  logic pulse_reg;
  logic chg_next;

  // Three flops; the first is only a metastability catcher
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= port.src;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts once stages two and three agree
  assign chg_next = (s2_reg == s3_reg) && (s3_reg != acc_reg);

  // Accept the new level and flag it for one cycle
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      acc_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end
    else
    begin
      if (chg_next)
        acc_reg <= s3_reg;
      pulse_reg <= chg_next;
    end
  end

  assign port.lvl = acc_reg;
  assign port.pulse = pulse_reg;
endmodule // lsd_evt_sync

// ===== verilog/lsd_err_timer.sv
`timescale 1ns/100ps
module lsd_err_timer
  import lsd_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_run,
  output logic o_done
);
  lsd_det_t st_reg; // Detection timer state
  logic [ERR_CNT_W-1:0] cnt_reg; // Cycles spent detecting

  // Counts the least detection time; a stop ends it at once
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_reg <= DET_IDLE;
      cnt_reg <= '0;
    end
    else if (!i_run)
    begin
      st_reg <= DET_IDLE;
      cnt_reg <= '0;
    end
    else
    begin
      case (st_reg)
        DET_IDLE:
        begin
          st_reg <= DET_RUN;
          cnt_reg <= '0;
        end
        DET_RUN:
        begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == ERR_CNT_W'(ERR_CYC - 1))
            st_reg <= DET_DONE;
        end
        DET_DONE:
          st_reg <= DET_DONE;
        default:
          st_reg <= DET_IDLE;
      endcase
    end
  end

  assign o_done = (st_reg == DET_DONE);

  chk_det_min_time: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(o_done) |-> $past(cnt_reg) == ERR_CNT_W'(ERR_CYC - 1))
    else $error("detection done before its least time");
endmodule // lsd_err_timer

// ===== verilog/lsd_top.sv
`timescale 1ns/100ps
// What this block does
// - One-edge strobe latches last sixteen bits
// - One-edge strobe instead stops open-LED detection while it runs
// - Two edges switch display to stored frame
// - Four edges load configuration one, MSB first
// - Five edges shift configuration one out
// - Seven edges start open-LED detection
// - Eight edges load configuration two
// - Nine edges shift configuration two out
// - Ten edges reset state, keep configuration
// - After reset channels dark until frame update
// - Writes ignored unless unlock came just before
// - Frame update ignored before sixteen latches
// - Configuration one resets to its default value
module lsd_top
  import lsd_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_serial_shift_clock,
  input wire logic i_serial_in,
  input wire logic i_command_strobe,
  output logic o_serial_out,
  output logic [NUM_WORDS-1:0] o_channel_sinks,
  output logic [WORD_W-1:0] o_cfg1,
  output logic [WORD_W-1:0] o_cfg2,
  output logic o_detect_active,
  output logic o_detect_done
);
  // Link side, on the serial shift clock
  logic [WORD_W-1:0] sh_reg; // Input shifter, also read-out shifter
  logic strobe_q_reg; // Strobe seen at the previous edge
  logic [CNT_W-1:0] cnt_reg; // Edges counted while strobe high
  logic unlock_reg; // Last command was the unlock
  logic det_reg; // Open-LED detection running
  logic [WORD_W-1:0] cfg1_reg;
  logic [WORD_W-1:0] cfg2_reg;
  logic [WORD_W-1:0] lword_reg; // Latched word held for the crossing
  logic [4:0] lcnt_reg; // Latches since power-up, saturating
  logic [CDC_N-1:0] tgl_reg; // Event toggles toward the other domain
  logic decode; // Strobe fell at this edge
  logic is_latch;
  logic is_stop;
  logic wr1_ok;
  logic wr2_ok;

  // Reference side
  logic [WORD_W-1:0] mem [NUM_WORDS]; // Stored frame
  logic [WORD_W-1:0] disp [NUM_WORDS]; // Displayed frame
  logic [3:0] wptr_reg; // Next frame memory slot
  lsd_disp_t disp_reg; // Channels on or dark
  logic [NUM_WORDS-1:0] sinks_reg;
  logic [WORD_W-1:0] ocfg1_reg;
  logic [WORD_W-1:0] ocfg2_reg;
  logic det_done;
  logic [CDC_N-1:0] cdc_pulse;
  logic [CDC_N-1:0] cdc_lvl;

  // Command is taken at the first edge with the strobe low again
  assign decode = strobe_q_reg && !i_command_strobe;
  // A one-edge command means stop while detection runs
  assign is_latch = decode && (cnt_reg == CMD_LATCH) && !det_reg;
  assign is_stop = decode && (cnt_reg == CMD_LATCH) && det_reg;
  assign wr1_ok = decode && (cnt_reg == CMD_WCFG1) && unlock_reg;
  assign wr2_ok = decode && (cnt_reg == CMD_WCFG2) && unlock_reg;

  // Strobe history and edge counter
  always_ff @(posedge i_serial_shift_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      strobe_q_reg <= 1'b0;
      cnt_reg <= '0;
    end
    else
    begin
      strobe_q_reg <= i_command_strobe;
      // Saturate so long strobes never wrap onto a valid code
      if (i_command_strobe && (cnt_reg != '1))
        cnt_reg <= cnt_reg + 1'b1;
      else if (!i_command_strobe)
        cnt_reg <= '0;
    end
  end

  // Shifter: every edge shifts, a read command reloads it
  always_ff @(posedge i_serial_shift_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      sh_reg <= '0;
    else if (decode && (cnt_reg == CMD_RCFG1))
      sh_reg <= cfg1_reg;
    else if (decode && (cnt_reg == CMD_RCFG2))
      sh_reg <= cfg2_reg;
    else
      sh_reg <= {sh_reg[WORD_W-2:0], i_serial_in};
  end

  // Serial output is the shifter's top bit, MSB leaves first
  assign o_serial_out = sh_reg[WORD_W-1];

  // Unlock is good for the very next command only
  always_ff @(posedge i_serial_shift_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      unlock_reg <= 1'b0;
    else if (decode)
      unlock_reg <= (cnt_reg == CMD_UNLOCK);
  end

  // Configuration registers survive a software reset
  always_ff @(posedge i_serial_shift_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cfg1_reg <= CFG1_RST;
      cfg2_reg <= CFG2_RST;
    end
    else
    begin
      if (wr1_ok)
        cfg1_reg <= sh_reg;
      if (wr2_ok)
        cfg2_reg <= sh_reg;
    end
  end

  // Detection run flag
  always_ff @(posedge i_serial_shift_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      det_reg <= 1'b0;
    else if (decode && (cnt_reg == CMD_DET_ON))
      det_reg <= 1'b1;
    else if (is_stop)
      det_reg <= 1'b0;
    else if (decode && (cnt_reg == CMD_SWRST))
      det_reg <= 1'b0;
  end

  // Latched word and power-up latch count
  always_ff @(posedge i_serial_shift_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      lword_reg <= '0;
      lcnt_reg <= '0;
    end
    else if (is_latch)
    begin
      lword_reg <= sh_reg;
      if (lcnt_reg != LATCH_MIN)
        lcnt_reg <= lcnt_reg + 1'b1;
    end
  end

  // Event toggles; the held words stay put for several
  // reference cycles, far longer than the three-flop crossing
  always_ff @(posedge i_serial_shift_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      tgl_reg <= '0;
    else
    begin
      if (is_latch)
        tgl_reg[CDC_LATCH] <= !tgl_reg[CDC_LATCH];
      if (decode && (cnt_reg == CMD_VSYNC) && (lcnt_reg == LATCH_MIN))
        tgl_reg[CDC_VSYNC] <= !tgl_reg[CDC_VSYNC];
      if (decode && (cnt_reg == CMD_SWRST))
        tgl_reg[CDC_SWRST] <= !tgl_reg[CDC_SWRST];
      if (wr1_ok || wr2_ok)
        tgl_reg[CDC_CFG] <= !tgl_reg[CDC_CFG];
      tgl_reg[CDC_DET] <= tgl_reg[CDC_DET];
    end
  end

  // One crossing per channel; detection passes as a level
  lsd_cdc_if cdc [CDC_N] ();
  genvar g;
  generate
    for (g = 0; g < CDC_N; g++)
    begin : g_cdc
      if (g == CDC_DET)
      begin : g_lvl
        assign cdc[g].src = det_reg;
      end
      else
      begin : g_tgl
        assign cdc[g].src = tgl_reg[g];
      end
      assign cdc_pulse[g] = cdc[g].pulse;
      assign cdc_lvl[g] = cdc[g].lvl;
      lsd_evt_sync u_sync (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .port(cdc[g])
      );
    end
  endgenerate

  // Frame memory fill; a software reset rewinds the pointer
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      wptr_reg <= '0;
    else if (cdc_pulse[CDC_SWRST])
      wptr_reg <= '0;
    else if (cdc_pulse[CDC_LATCH])
      wptr_reg <= wptr_reg + 1'b1;
  end

  // Stored words are kept across a software reset
  always_ff @(posedge i_ref_clk)
  begin
    if (cdc_pulse[CDC_LATCH])
      mem[wptr_reg] <= lword_reg;
  end

  // Frame update copies the whole stored frame
  always_ff @(posedge i_ref_clk)
  begin
    if (cdc_pulse[CDC_VSYNC])
      disp <= mem;
  end

  // Display state: dark after reset until a frame update
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      disp_reg <= DISP_OFF;
    else if (cdc_pulse[CDC_SWRST])
      disp_reg <= DISP_OFF;
    else if (cdc_pulse[CDC_VSYNC])
      disp_reg <= DISP_ON;
  end

  // Channel sinks; the pulse-width engine is outside this block
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      sinks_reg <= '0;
    else
      for (int i = 0; i < NUM_WORDS; i++)
        sinks_reg[i] <= (disp_reg == DISP_ON) && (|disp[i]);
  end

  // Configuration copies for the rest of the chip
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ocfg1_reg <= CFG1_RST;
      ocfg2_reg <= CFG2_RST;
    end
    else if (cdc_pulse[CDC_CFG])
    begin
      ocfg1_reg <= cfg1_reg;
      ocfg2_reg <= cfg2_reg;
    end
  end

  // Detection least-time counter
  lsd_err_timer u_timer (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_run(cdc_lvl[CDC_DET]),
    .o_done(det_done)
  );

  // Detection flags registered for the ports
  logic det_act_reg;
  logic det_done_reg;
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      det_act_reg <= 1'b0;
      det_done_reg <= 1'b0;
    end
    else
    begin
      det_act_reg <= cdc_lvl[CDC_DET];
      det_done_reg <= det_done;
    end
  end

  assign o_channel_sinks = sinks_reg;
  assign o_cfg1 = ocfg1_reg;
  assign o_cfg2 = ocfg2_reg;
  assign o_detect_active = det_act_reg;
  assign o_detect_done = det_done_reg;

  // Checks on the link side
  chk_latch_word_take: assert property (@(posedge i_serial_shift_clock)
    disable iff (!i_arst_n)
    is_latch |=> (lword_reg == $past(sh_reg)) && $changed(tgl_reg[CDC_LATCH]))
    else $error("latch did not capture the shifter");

  chk_stop_no_latch: assert property (@(posedge i_serial_shift_clock)
    disable iff (!i_arst_n)
    is_stop |=> !det_reg && $stable(lword_reg) && $stable(tgl_reg[CDC_LATCH]))
    else $error("stop command misbehaved");

  chk_cfg1_load: assert property (@(posedge i_serial_shift_clock)
    disable iff (!i_arst_n)
    wr1_ok |=> cfg1_reg == $past(sh_reg))
    else $error("configuration one not loaded");

  chk_cfg1_readout: assert property (@(posedge i_serial_shift_clock)
    disable iff (!i_arst_n)
    (decode && (cnt_reg == CMD_RCFG1)) |=> o_serial_out == $past(cfg1_reg[WORD_W-1])
      ##1 o_serial_out == $past(cfg1_reg[WORD_W-2], 2))
    else $error("configuration one read-out wrong");

  chk_det_start_cmd: assert property (@(posedge i_serial_shift_clock)
    disable iff (!i_arst_n)
    (decode && (cnt_reg == CMD_DET_ON)) |=> det_reg)
    else $error("detection did not start");

  chk_cfg2_load: assert property (@(posedge i_serial_shift_clock)
    disable iff (!i_arst_n)
    wr2_ok |=> cfg2_reg == $past(sh_reg) && $stable(cfg1_reg))
    else $error("configuration two not loaded");

  chk_cfg2_readout: assert property (@(posedge i_serial_shift_clock)
    disable iff (!i_arst_n)
    (decode && (cnt_reg == CMD_RCFG2)) |=> sh_reg == $past(cfg2_reg))
    else $error("configuration two read-out wrong");

  chk_swrst_keeps_cfg: assert property (@(posedge i_serial_shift_clock)
    disable iff (!i_arst_n)
    (decode && (cnt_reg == CMD_SWRST)) |=> $stable(cfg1_reg) && $stable(cfg2_reg)
      && !det_reg && !unlock_reg)
    else $error("software reset touched configuration");

  chk_locked_write: assert property (@(posedge i_serial_shift_clock)
    disable iff (!i_arst_n)
    (decode && (cnt_reg == CMD_WCFG1) && !unlock_reg) |=> $stable(cfg1_reg))
    else $error("write taken without unlock");

  chk_vsync_gate: assert property (@(posedge i_serial_shift_clock)
    disable iff (!i_arst_n)
    (decode && (cnt_reg == CMD_VSYNC) && (lcnt_reg != LATCH_MIN))
      |=> $stable(tgl_reg[CDC_VSYNC]))
    else $error("frame update taken too early");

  // Checks on the reference side
  chk_vsync_shows: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    cdc_pulse[CDC_VSYNC] && !cdc_pulse[CDC_SWRST] |=> (disp_reg == DISP_ON)
      && (disp[0] == $past(mem[0])))
    else $error("frame update not shown");

  chk_swrst_dark: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    cdc_pulse[CDC_SWRST] |=> ##1 (o_channel_sinks == '0))
    else $error("channels not dark after reset");
endmodule // lsd_top

// ===== tb/lsd_ctrl_model.sv
`timescale 1ns/100ps
// Display controller model: frames the serial word, counts strobe edges, reads back
module lsd_ctrl_model
(
  input wire logic i_serial_out,
  output logic o_sclk,
  output logic o_sdata,
  output logic o_strobe
);
  // Free-running 6 ns base; the link clock follows it only inside a bitx call
  logic base_clk = 1'b0;
  // High while a frame is on the wire
  logic busy = 1'b0;
  initial
  begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_strobe = 1'b0;
  end
  always #3 base_clk = ~base_clk;
  // Idle data line toggles so a stale bit never looks valid
  always @(posedge base_clk)
  begin
    if (!busy)
      o_sdata <= ~o_sdata;
  end
  // One 6 ns link period: fall with new data and strobe, rise half a period later.
  // The clock then rests high, so no edge appears between frames.
  task automatic bitx(input logic b, input logic s);
    @(negedge base_clk);
    o_sclk = 1'b0;
    o_sdata = b;
    o_strobe = s;
    @(posedge base_clk);
    o_sclk = 1'b1;
  endtask
  // Link edges with the strobe low, used around reset
  task automatic idle(input int n);
    repeat (n) bitx(1'b0, 1'b0);
  endtask
  // Word MSB first, strobe high on the last n edges, then one low edge
  task automatic send(input logic [15:0] w, input int n);
    busy = 1'b1;
    for (int i = 15; i >= 0; i--)
      bitx(w[i], i < n);
    bitx(1'b0, 1'b0);
    busy = 1'b0;
  endtask
  // Read command, then collect sixteen bits MSB first, each a little after its edge
  task automatic read(input int n, output logic [15:0] w);
    send(16'h0000, n);
    #1;
    w[15] = i_serial_out;
    for (int i = 14; i >= 0; i--)
    begin
      bitx(1'b0, 1'b0);
      #1;
      w[i] = i_serial_out;
    end
  endtask
endmodule // lsd_ctrl_model

// ===== tb/lsd_top_test.sv
`timescale 1ns/100ps
// Self-checking bench for the serial command front end
module lsd_top_test;
  import lsd_pkg::*;
  logic ref_clk = 1'b0; // 200 MHz reference
  logic arst_n = 1'b0; // Asynchronous reset, active low
  logic sclk; // Link clock from the controller
  logic sdata; // Serial data in
  logic strobe; // Command strobe
  logic sout; // Serial data out
  logic [NUM_WORDS-1:0] sinks;
  logic [WORD_W-1:0] cfg1;
  logic [WORD_W-1:0] cfg2;
  logic det_act;
  logic det_done;
  logic [31:0] rnd_state = 32'h0000_36a0; // Fixed seed
  logic [15:0] mem [NUM_WORDS]; // Expected frame words
  logic [15:0] v1;
  logic [15:0] v2;
  logic [15:0] rd;
  int failures = 0;
  int cmp_count = 0;
  int wt;
  // Even duty, as a square grayscale-side clock must have
  always #2.5 ref_clk = ~ref_clk;
  lsd_ctrl_model ctrl (
    .i_serial_out(sout),
    .o_sclk(sclk),
    .o_sdata(sdata),
    .o_strobe(strobe)
  );
  lsd_top dut (
    .i_ref_clk(ref_clk),
    .i_arst_n(arst_n),
    .i_serial_shift_clock(sclk),
    .i_serial_in(sdata),
    .i_command_strobe(strobe),
    .o_serial_out(sout),
    .o_channel_sinks(sinks),
    .o_cfg1(cfg1),
    .o_cfg2(cfg2),
    .o_detect_active(det_act),
    .o_detect_done(det_done)
  );
  // Xorshift step for repeatable stimulus
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic rnd16(output logic [15:0] r);
    rnd_state = xs(rnd_state);
    r = rnd_state[15:0];
  endtask
  // A channel is on when its stored word is nonzero
  function automatic logic [15:0] exp_sinks();
    logic [15:0] e;
    for (int i = 0; i < NUM_WORDS; i++)
      e[i] = (mem[i] != 16'h0000);
    return e;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Command, then room for the 4 to 6 cycle crossing
  task automatic cmd(input logic [15:0] w, input logic [3:0] n);
    ctrl.send(w, int'(n));
    repeat (12) @(negedge ref_clk);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog: the sequence needs about 6 us
  initial
  begin
    #40000;
    failures++;
    test_done();
  end
  initial
  begin
    // Two link edges fall inside the 16-cycle reset
    fork
      ctrl.idle(2);
    join_none
    repeat (16) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    check(cfg1, CFG1_RST);
    check(cfg2, CFG2_RST);
    check(sinks, 16'h0000);
    check({14'h0000, det_act, det_done}, 16'h0000);
    $display("test reset done");
    // Sixteen latches; an update after fifteen must be ignored
    for (int k = 0; k < NUM_WORDS; k++)
    begin
      rnd16(mem[k]);
      if (k == 3 || k == 9)
        mem[k] = 16'h0000;
      if (k == 0)
        mem[k] = mem[k] | 16'h8001;
      cmd(mem[k], CMD_LATCH);
      if (k == 14)
      begin
        cmd(16'h0000, CMD_VSYNC);
        check(sinks, 16'h0000);
      end
    end
    cmd(16'h0000, CMD_VSYNC);
    check(sinks, exp_sinks());
    $display("test latch done");
    // Writes without, with, and not directly after unlock
    rnd16(v1);
    cmd(v1, CMD_WCFG1);
    check(cfg1, CFG1_RST);
    cmd(16'h0000, CMD_UNLOCK);
    cmd(v1, CMD_WCFG1);
    check(cfg1, v1);
    ctrl.read(int'(CMD_RCFG1), rd);
    check(rd, v1);
    rnd16(v2);
    cmd(16'h0000, CMD_UNLOCK);
    cmd(v2, CMD_WCFG2);
    check(cfg2, v2);
    ctrl.read(int'(CMD_RCFG2), rd);
    check(rd, v2);
    cmd(16'h0000, CMD_UNLOCK);
    cmd(16'h0000, CMD_VSYNC);
    cmd(~v1, CMD_WCFG1);
    check(cfg1, v1);
    $display("test config done");
    // Detection runs its least time; a one-edge command only stops it
    cmd(16'h0000, CMD_DET_ON);
    check({15'h0000, det_act}, 16'h0001);
    check({15'h0000, det_done}, 16'h0000);
    wt = 0;
    while (wt < 300 && det_done !== 1'b1)
    begin
      @(negedge ref_clk);
      wt++;
    end
    check({15'h0000, det_done}, 16'h0001);
    // Twelve reference cycles already passed inside the command call
    check({15'h0000, (wt + 12 >= ERR_CYC)}, 16'h0001);
    cmd(16'h0000, CMD_LATCH);
    check({15'h0000, det_act}, 16'h0000);
    cmd(16'h0000, CMD_VSYNC);
    check(sinks, exp_sinks());
    $display("test detect done");
    // Software reset darkens channels, keeps configuration and words
    cmd(16'h0000, CMD_DET_ON);
    cmd(16'h0000, CMD_SWRST);
    check(sinks, 16'h0000);
    check(cfg1, v1);
    check(cfg2, v2);
    check({15'h0000, det_act}, 16'h0000);
    cmd(16'h0000, CMD_VSYNC);
    check(sinks, exp_sinks());
    $display("test swreset done");
    test_done();
  end
endmodule // lsd_top_test
